// ==== logic/iohc_regs.vh ====
// constants for the i/o bus host controller (computer side of the i/o bus)
// assumes one 125 MHz clock; controllers answer on the done handshake
// Summary of operation
// R1 - select broadcasts select strobes and 24-bit select word on output bus
// R2 - only addressed controller activates and latches transfer conditions
// R3 - controller raises done handshake with 24 status bits on input bus
// R4 - select names status destination register; select may ask status only
// R5 - transfer action field yields input, output or status strobes
// R6 - controller raises done handshake when transfer finished
// R7 - four channels; a selected controller gets a channel nobody holds
// R8 - controller interrupts on its channel when ready for data
// R9 - computer drives enable on the channel when a transfer starts
// R10 - commutator steps four counts, one channel per clock
// R11 - commutator locks on interrupting channel if auto interrupt enabled
// R12 - branch target is base location plus locked channel number
// R13 - lock holds until program release or console reset
// R14 - pending interrupts stay visible to software when auto disabled
// R15 - computer waits for done handshake during select or transfer; a disconnect (action 0) goes to end without waiting
// R16 - controllers should keep command processing short
// R17 - select word bits 00..23 hold status, type, number, format, device, channel, op
// R18 - nonzero format bits 07..08 reinterpret word for high-speed adaptor
// R19 - bit 00 one means status only, zero means data selection
// R20 - status-only select does not activate the controller
// R21 - data selection brings controller on-line and starts function
// R22 - controller holds last commanded mode until new command
// R23 - controller buffers data and detects errors
// R24 - select bits 12..13 give channel zero to three
// R25 - controller drops done handshake as soon as command ends
// R26 - disconnected controller sends no interrupts and no data
// R27 - status stays on input bus while done handshake is high
`ifndef IOHC_REGS_VH
`define IOHC_REGS_VH
`define IOHC_WORD_W        24
`define IOHC_BIT_STATUS    0
`define IOHC_FMT_LO        7
`define IOHC_FMT_HI        8
`define IOHC_CHAN_HI       12
`define IOHC_CHAN_LO       13
`define IOHC_ACT_DSC       3'h0
`define IOHC_ACT_STATUS    3'h7
`define IOHC_VEC_BASE      15'h7000
`define IOHC_WAIT_NS       4000
`define IOHC_CLK_NS        8
`define IOHC_WAIT_CYC      (`IOHC_WAIT_NS / `IOHC_CLK_NS)
`endif

// ==== logic/iohc_mem.v ====
// four-word store of the last status word per channel
// assumes single clock, registered read
`timescale 1ns/1ps
`include "iohc_regs.vh"
module iohc_mem (
	input  wire        clock_i,
	input  wire        we_i,
	input  wire [1:0]  waddr_i,
	input  wire [23:0] wdata_i,
	input  wire [1:0]  raddr_i,
	output reg  [23:0] rdata_o
);
	reg [23:0] mem [0:3];
	always @(posedge clock_i) begin
		if (we_i) begin
			mem[waddr_i] <= wdata_i;
		end
		rdata_o <= mem[raddr_i];
	end
endmodule

// ==== logic/iohc_host.v ====
// i/o bus host: issues select and transfer commands, scans interrupt channels
// assumes controllers answer with command_done_handshake; inputs synchronous
`timescale 1ns/1ps
`include "iohc_regs.vh"
module iohc_host #(
	parameter WAIT_CYC = `IOHC_WAIT_CYC
) (
	input  wire        clock_i,
	input  wire        rst_n_i,
	// user side
	input  wire        sel_req_i,
	input  wire [23:0] sel_word_i,
	input  wire        xfr_req_i,
	input  wire [2:0]  xfr_act_i,
	input  wire [1:0]  xfr_chan_i,
	input  wire [23:0] xfr_wdata_i,
	input  wire [3:0]  auto_en_i,
	input  wire        lock_release_i,
	input  wire [1:0]  stat_rd_chan_i,
	output reg         busy_o,
	output reg         done_o,
	output reg         timeout_o,
	output reg  [23:0] rdata_o,
	output reg         chan_err_o,
	output reg  [3:0]  chan_held_o,
	output reg  [3:0]  irq_pend_o,
	output reg         locked_o,
	output reg  [14:0] vector_o,
	output wire [23:0] stat_rd_o,
	// bus side
	output reg  [23:0] out_bus_o,
	output reg         sel_strobe_o,
	output reg         stat_strobe_o,
	output reg         xfer_in_o,
	output reg         xfer_out_o,
	output reg         eom_o,
	output reg         disc_o,
	output reg  [3:0]  chan_en_o,
	input  wire [23:0] in_bus_i,
	input  wire        command_done_handshake_i,
	input  wire [3:0]  chan_irq_i
);
	localparam ST_IDLE = 2'h0;
	localparam ST_WAIT = 2'h1;
	localparam ST_END  = 2'h2;

	reg [1:0]  state_r;
	reg [1:0]  comm_r;
	reg [15:0] wait_r;
	reg        is_sel_r;
	reg        stat_only_r;
	reg [1:0]  cmd_chan_r;
	reg        st_we_r;

	function [3:0] onehot;
		input [1:0] c;
		begin
			onehot = 4'h1 << c;
		end
	endfunction

	// ----------------------------------------
	// select word decode
	// ----------------------------------------
	// R18 adaptor words carry no channel field
	function chan_word;
		input [23:0] w;
		begin
			chan_word = !w[`IOHC_BIT_STATUS] &&
			            (w[`IOHC_FMT_HI:`IOHC_FMT_LO] == 2'h0);
		end
	endfunction

	iohc_mem u_mem (
		.clock_i (clock_i),
		.we_i    (st_we_r),
		.waddr_i (cmd_chan_r),
		.wdata_i (rdata_o),
		.raddr_i (stat_rd_chan_i),
		.rdata_o (stat_rd_o)
	);

	// ----------------------------------------
	// commutator
	// ----------------------------------------
	always @(posedge clock_i) begin
		if (!rst_n_i) begin
			comm_r     <= 2'h0;
			locked_o   <= 1'b0;
			vector_o   <= `IOHC_VEC_BASE;
			irq_pend_o <= 4'h0;
		end else begin
			// R14 pending visible
			irq_pend_o <= chan_irq_i;
			if (locked_o) begin
				// R13 hold lock
				if (lock_release_i) begin
					locked_o <= 1'b0;
				end
			// R11 lock on channel
			end else if (chan_irq_i[comm_r] && auto_en_i[comm_r]) begin
				locked_o <= 1'b1;
				// R12 vector base plus channel
				vector_o <= `IOHC_VEC_BASE + {13'h0, comm_r};
			end else begin
				// R10 four-count scan
				comm_r <= comm_r + 2'h1;
			end
		end
	end

	// ----------------------------------------
	// command sequencer
	// ----------------------------------------
	always @(posedge clock_i) begin
		if (!rst_n_i) begin
			state_r       <= ST_IDLE;
			wait_r        <= 16'h0000;
			is_sel_r      <= 1'b0;
			stat_only_r   <= 1'b0;
			cmd_chan_r    <= 2'h0;
			st_we_r       <= 1'b0;
			busy_o        <= 1'b0;
			done_o        <= 1'b0;
			timeout_o     <= 1'b0;
			rdata_o       <= 24'h000000;
			chan_err_o    <= 1'b0;
			chan_held_o   <= 4'h0;
			out_bus_o     <= 24'h000000;
			sel_strobe_o  <= 1'b0;
			stat_strobe_o <= 1'b0;
			xfer_in_o     <= 1'b0;
			xfer_out_o    <= 1'b0;
			eom_o         <= 1'b0;
			disc_o        <= 1'b0;
			chan_en_o     <= 4'h0;
		end else begin
			done_o     <= 1'b0;
			chan_err_o <= 1'b0;
			st_we_r    <= 1'b0;
			case (state_r)
			ST_IDLE: begin
				timeout_o <= 1'b0;
				wait_r    <= 16'h0000;
				if (sel_req_i) begin
					// R7 channel must be free for data select
					if (chan_word(sel_word_i) &&
					    chan_held_o[{sel_word_i[`IOHC_CHAN_HI], sel_word_i[`IOHC_CHAN_LO]}]) begin
						chan_err_o <= 1'b1;
					end else begin
						// R1 R17 broadcast whole select word
						out_bus_o    <= sel_word_i;
						sel_strobe_o <= 1'b1;
						// R19 status-only bit
						stat_strobe_o <= sel_word_i[`IOHC_BIT_STATUS];
						stat_only_r  <= !chan_word(sel_word_i);
						// R24 channel bits
						cmd_chan_r   <= {sel_word_i[`IOHC_CHAN_HI], sel_word_i[`IOHC_CHAN_LO]};
						is_sel_r     <= 1'b1;
						busy_o       <= 1'b1;
						state_r      <= ST_WAIT;
					end
				end else if (xfr_req_i) begin
					// R5 action field to strobes
					out_bus_o     <= xfr_wdata_i;
					is_sel_r      <= 1'b0;
					cmd_chan_r    <= xfr_chan_i;
					disc_o        <= (xfr_act_i == `IOHC_ACT_DSC);
					stat_strobe_o <= (xfr_act_i == `IOHC_ACT_STATUS);
					xfer_in_o     <= (xfr_act_i != `IOHC_ACT_STATUS) && xfr_act_i[0];
					xfer_out_o    <= (xfr_act_i != `IOHC_ACT_STATUS) && xfr_act_i[1];
					eom_o         <= (xfr_act_i != `IOHC_ACT_STATUS) && xfr_act_i[2];
					// R9 channel enable
					chan_en_o     <= onehot(xfr_chan_i);
					busy_o        <= 1'b1;
					// disconnect is ended by the host itself
					if (xfr_act_i == `IOHC_ACT_DSC) begin
						chan_held_o <= chan_held_o & ~onehot(xfr_chan_i);
						state_r     <= ST_END;
					end else begin
						state_r     <= ST_WAIT;
					end
				end
			end
			ST_WAIT: begin
				wait_r <= wait_r + 16'h0001;
				// R15 wait for handshake
				if (command_done_handshake_i) begin
					// R3 capture status with handshake
					rdata_o <= in_bus_i;
					st_we_r <= is_sel_r;
					if (is_sel_r && !stat_only_r) begin
						chan_held_o <= chan_held_o | onehot(cmd_chan_r);
					end
					state_r <= ST_END;
				// R16 bound on controller time
				end else if (wait_r == WAIT_CYC[15:0]) begin
					timeout_o <= 1'b1;
					state_r   <= ST_END;
				end
			end
			ST_END: begin
				// R25 end command, wait for handshake to drop
				out_bus_o     <= 24'h000000;
				sel_strobe_o  <= 1'b0;
				stat_strobe_o <= 1'b0;
				xfer_in_o     <= 1'b0;
				xfer_out_o    <= 1'b0;
				eom_o         <= 1'b0;
				disc_o        <= 1'b0;
				chan_en_o     <= 4'h0;
				if (!command_done_handshake_i) begin
					busy_o  <= 1'b0;
					done_o  <= 1'b1;
					state_r <= ST_IDLE;
				end
			end
			default: begin
				state_r <= ST_IDLE;
			end
			endcase
		end
	end
endmodule

// ==== verif/iohc_host_props.sv ====
// assertions on the iohc_host ports
// assumes a bind onto iohc_host, one clock
`timescale 1ns/1ps
module iohc_host_props (
	input wire        clock_i, rst_n_i, sel_strobe_o, stat_strobe_o, busy_o, locked_o, lock_release_i,
	input wire        command_done_handshake_i, xfer_in_o, xfer_out_o, eom_o,
	input wire [23:0] sel_word_i, out_bus_o, in_bus_i, rdata_o,
	input wire [2:0]  xfr_act_i,
	input wire [3:0]  irq_pend_o, chan_irq_i,
	input wire [14:0] vector_o
);
	// ----------
	// properties
	// ----------
	wire [2:0] act_w = {eom_o, xfer_out_o, xfer_in_o};
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	sel_word_a: assert property ($rose(sel_strobe_o) |-> out_bus_o == $past(sel_word_i)) else $error("word");
	stat_only_a: assert property (sel_strobe_o |-> stat_strobe_o == out_bus_o[0]) else $error("stat");
	wait_done_a: assert property (sel_strobe_o && !command_done_handshake_i |=> sel_strobe_o) else $error("wait");
	stat_cap_a: assert property ($rose(command_done_handshake_i) && sel_strobe_o |=> rdata_o == $past(in_bus_i))
		else $error("capture");
	act_map_a: assert property ($rose(busy_o) && !sel_strobe_o && $past(xfr_act_i) < 3'h7 |-> act_w == $past(xfr_act_i))
		else $error("action");
	lock_hold_a: assert property (locked_o && !lock_release_i |=> locked_o && $stable(vector_o)) else $error("lock");
	vec_base_a: assert property (locked_o |-> vector_o[14:2] == 13'h1c00) else $error("vector");
	pend_vis_a: assert property ($past(rst_n_i) |-> irq_pend_o == $past(chan_irq_i)) else $error("pend");
	sel_c: cover property (sel_strobe_o && command_done_handshake_i);
	xfr_c: cover property (xfer_out_o && command_done_handshake_i);
	lock_c: cover property ($rose(locked_o));
endmodule
bind iohc_host iohc_host_props u_props (.clock_i, .rst_n_i, .sel_strobe_o, .stat_strobe_o, .busy_o, .locked_o,
	.lock_release_i, .command_done_handshake_i, .xfer_in_o, .xfer_out_o, .eom_o, .sel_word_i, .out_bus_o,
	.in_bus_i, .rdata_o, .xfr_act_i, .irq_pend_o, .chan_irq_i, .vector_o);

// ==== verif/iohc_dev_model.sv ====
// device model: answers host commands with the done handshake
// assumes host strobes; answer delay set by the bench
`timescale 1ns/1ps
module iohc_dev_model (
	input  wire        clock_i,
	input  wire        sel_i,
	input  wire        cmd_i,
	input  wire        disc_i,
	input  wire [23:0] q_i,
	input  wire [3:0]  dly_i,
	input  wire        irq_want_i,
	output reg  [23:0] r_o = 24'h0,
	output reg         done_o = 1'h0,
	output reg  [3:0]  irq_o = 4'h0
);
	// ----------
	// answer logic
	// ----------
	reg [3:0] cnt_r = 4'h0;
	reg [1:0] chan_r = 2'h0;
	reg       on_r = 1'h0;
	always @(posedge clock_i) begin
		irq_o <= {3'h0, on_r & irq_want_i} << chan_r;
		if (!cmd_i) begin
			done_o <= 1'h0;
			cnt_r <= 4'h0;
			r_o <= ~r_o;
		end else if (cnt_r != dly_i) begin
			cnt_r <= cnt_r + 4'h1;
		end else if (!done_o) begin
			done_o <= 1'h1;
			r_o <= q_i ^ 24'h5a5a5a;
			on_r <= on_r | sel_i & !q_i[0];
			if (sel_i && !q_i[0])
				chan_r <= {q_i[12], q_i[13]};
		end
		if (disc_i)
			on_r <= 1'h0;
	end
endmodule

// ==== verif/io_bus_device_controller_tb.sv ====
// bench for iohc_host with a device model on the bus side
// assumes answer delays well below WAIT_CYC of 20
`timescale 1ns/1ps
module io_bus_device_controller_tb;
	reg         clock_i, rst_n_i, sel_req_i, xfr_req_i, lock_release_i, irq_want;
	reg  [23:0] sel_word_i, xfr_wdata_i, w;
	reg  [2:0]  xfr_act_i;
	reg  [1:0]  xfr_chan_i, stat_rd_chan_i;
	reg  [3:0]  auto_en_i, dly;
	wire        busy_o, done_o, timeout_o, chan_err_o, locked_o, sel_strobe_o, stat_strobe_o;
	wire        xfer_in_o, xfer_out_o, eom_o, disc_o, command_done_handshake_i;
	wire [23:0] rdata_o, stat_rd_o, out_bus_o, in_bus_i;
	wire [3:0]  chan_held_o, irq_pend_o, chan_en_o, chan_irq_i;
	wire [14:0] vector_o;
	integer     bad_count = 0, n_tests = 0, cyc = 0, i, k;
	iohc_host #(.WAIT_CYC(20)) dut (.clock_i, .rst_n_i, .sel_req_i, .sel_word_i, .xfr_req_i, .xfr_act_i,
		.xfr_chan_i, .xfr_wdata_i, .auto_en_i, .lock_release_i, .stat_rd_chan_i, .busy_o, .done_o, .timeout_o,
		.rdata_o, .chan_err_o, .chan_held_o, .irq_pend_o, .locked_o, .vector_o, .stat_rd_o, .out_bus_o,
		.sel_strobe_o, .stat_strobe_o, .xfer_in_o, .xfer_out_o, .eom_o, .disc_o, .chan_en_o, .in_bus_i,
		.command_done_handshake_i, .chan_irq_i);
	iohc_dev_model dev (.clock_i, .sel_i(sel_strobe_o),
		.cmd_i(sel_strobe_o | stat_strobe_o | xfer_in_o | xfer_out_o | eom_o),
		.disc_i(disc_o), .q_i(out_bus_o), .dly_i(dly), .irq_want_i(irq_want), .r_o(in_bus_i),
		.done_o(command_done_handshake_i), .irq_o(chan_irq_i));
	// ----------
	// tasks
	// ----------
	task step(input integer n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask
	task check(input string what, input [23:0] seen, input [23:0] exp);
		n_tests = n_tests + 1;
		if (seen !== exp) begin
			bad_count = bad_count + 1;
			$display("BAD %s exp %h seen %h", what, exp, seen);
		end
	endtask
	task run(input s, input [23:0] wd, input [2:0] a, input [1:0] e);
		dly = $urandom_range(9, 0);
		stat_rd_chan_i = $urandom;
		sel_req_i = s;
		xfr_req_i = !s;
		sel_word_i = wd;
		xfr_wdata_i = wd;
		xfr_act_i = a;
		xfr_chan_i = {wd[12], wd[13]};
		step(1);
		sel_req_i = 0;
		xfr_req_i = 0;
		xfr_act_i = 3'h7;
		for (k = 0; k < 40 && !done_o && !chan_err_o; k = k + 1)
			step(1);
		check("end", {done_o, chan_err_o}, e);
		check("timeout", timeout_o, 1'h0);
		step(1);
	endtask
	task end_sim;
		$display("checks %0d bad %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// ----------
	// sequence
	// ----------
	initial begin
		clock_i = 0;
		forever #4 clock_i = ~clock_i;
	end
	always @(posedge clock_i) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			bad_count = bad_count + 1;
			end_sim;
		end
	end
	initial begin
		{rst_n_i, sel_req_i, xfr_req_i, lock_release_i, irq_want, sel_word_i, xfr_wdata_i} = 0;
		{xfr_act_i, xfr_chan_i, stat_rd_chan_i, auto_en_i, dly} = 15'h7000;
		void'($urandom(32'hff90fe88));
		step(6);
		rst_n_i = 1;
		step(1);
		for (i = 0; i < 4; i = i + 1) begin
			w = $urandom & 24'hffce7e | {i[0], i[1], 12'h0};
			run(1, w, 3'h7, 2'h2);
			check("status", rdata_o, w ^ 24'h5a5a5a);
			stat_rd_chan_i = i;
			step(2);
			check("last status", stat_rd_o, w ^ 24'h5a5a5a);
		end
		check("held", chan_held_o, 4'hf);
		run(1, 24'h002000, 3'h7, 2'h1);
		for (i = 0; i < 6; i = i + 1) begin
			w = $urandom & 24'hfffe7f | 24'h1;
			run(1, w, 3'h7, 2'h2);
			check("stat only", rdata_o ^ {20'h0, chan_held_o}, w ^ 24'h5a5a55);
		end
		$display("test select done");
		for (i = 1; i < 8; i = i + 1)
			run(0, 24'h003000, i, 2'h2);
		irq_want = 1;
		step(4);
		check("pending", {locked_o, irq_pend_o}, 5'h08);
		auto_en_i = 4'h8;
		step(8);
		check("vector", {locked_o, vector_o}, 16'hf003);
		irq_want = 0;
		step(5);
		check("hold", locked_o, 1'h1);
		lock_release_i = 1;
		step(1);
		lock_release_i = 0;
		step(2);
		check("release", locked_o, 1'h0);
		run(0, 24'h003000, 3'h0, 2'h2);
		irq_want = 1;
		step(4);
		check("freed", {chan_held_o, irq_pend_o}, 8'h70);
		$display("test channel done");
		end_sim;
	end
endmodule
